// *** core/rlf_pkg.sv ***
// package: constants and types for the redundant link failover controller
package rlf_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 10_000_000;
  localparam int SWITCH_MAX_MS   = 10;
  localparam int SWITCH_TYP_MS   = 6;
  // microseconds the primary stays off before the secondary comes on
  localparam int GAP_US          = 3000;
  localparam int GAP_CYC         = (GAP_US * (CLK_HZ / 1_000_000));
  localparam int SWITCH_MAX_CYC  = SWITCH_MAX_MS * (CLK_HZ / 1000);
  localparam int CNT_W           = 16;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

  // ----------------------------------------------------------------
  // fault cause bit positions
  // ----------------------------------------------------------------
  localparam int F_LINK   = 0;
  localparam int F_COLL   = 1;
  localparam int F_LONG   = 2;
  localparam int F_JAB    = 3;
  localparam int F_XCVR   = 4;
  localparam int F_REMOTE = 5;
  localparam int F_DIS    = 6;
  localparam int FW       = 7;

  typedef enum logic [2:0] {
    RLF_PRI_ACT,
    RLF_GAP,
    RLF_SEC_ACT,
    RLF_BOTH_OFF
  } rlf_state_t;
endpackage : rlf_pkg

// *** core/rlf_port_if.sv ***
// interface: fault inputs of one master port
`timescale 1ns/1ps
interface rlf_port_if;
  import rlf_pkg::*;
  logic [FW-1:0] cause;
  logic          responder;
  logic          failed;
  modport src (output cause, output responder, input failed);
  modport mon (input cause, input responder, output failed);
endinterface : rlf_port_if

// *** core/rlf_port_mon.sv ***
// module: fault condenser for one master port
`timescale 1ns/1ps
module rlf_port_mon
  import rlf_pkg::*;
(
  rlf_port_if.mon p
);
  // ----------------------------------------------------------------
  // fault reduction
  // ----------------------------------------------------------------
  logic [FW-1:0] mask;
  always_comb
  begin
    mask = '1;
    // a nonresponder never reports, so its remote bit is ignored
    mask[F_REMOTE] = p.responder;
  end
  assign p.failed = |(p.cause & mask);
endmodule : rlf_port_mon

// *** core/rlf_ctrl.sv ***
// module: failover controller for a redundant link pair
`timescale 1ns/1ps
// Contract
// - at start the primary port becomes active if it has no failure.
// - after reset the primary is active again whatever was active before.
// - at start and after reset the secondary is held in standby.
// - the two master ports are never active together.
// - on primary failure the primary is disabled first, then the secondary enabled.
// - the switchover completes within 10 ms of the failure being detected.
// - a repaired primary stays off until the secondary fails or a reboot.
// - the state of both links is held as readable status.
// - every link state transition of the pair is counted until the count saturates at all ones.
// - which physical port is primary is chosen by management.
// - with a nonresponder only local failures are used.
// - link loss, partitioning causes and transceiver fault are failures.
// - a responder failure report counts as a failure of the port it faces, primary or secondary.
module rlf_ctrl
  import rlf_pkg::*;
#(
  parameter int GAP_CYCLES = GAP_CYC
)(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 swap_roles,
  input  wire logic [rlf_pkg::FW-1:0] port_a_cause,
  input  wire logic [rlf_pkg::FW-1:0] port_b_cause,
  input  wire logic                 port_a_responder,
  input  wire logic                 port_b_responder,
  output logic                      port_a_enable,
  output logic                      port_b_enable,
  output logic                      port_a_fail,
  output logic                      port_b_fail,
  output logic                      on_secondary,
  output logic [rlf_pkg::CNT_W-1:0] transition_count
);
  import rlf_pkg::*;

  // ----------------------------------------------------------------
  // per-port fault condensing
  // ----------------------------------------------------------------
  rlf_port_if pa ();
  rlf_port_if pb ();
  assign pa.cause     = port_a_cause;
  assign pa.responder = port_a_responder;
  assign pb.cause     = port_b_cause;
  assign pb.responder = port_b_responder;
  rlf_port_mon u_mon_a (.p(pa));
  rlf_port_mon u_mon_b (.p(pb));

  // role swap only applies at reset so live traffic never flips
  logic swap_q;
  logic swap_seen_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      swap_q      <= 1'b0;
      swap_seen_q <= 1'b0;
    end
    else if (!swap_seen_q)
    begin
      swap_q      <= swap_roles;
      swap_seen_q <= 1'b1;
    end
  end

  logic pri_fail;
  logic sec_fail;
  assign pri_fail = swap_q ? pb.failed : pa.failed;
  assign sec_fail = swap_q ? pa.failed : pb.failed;

  // ----------------------------------------------------------------
  // switchover state machine
  // ----------------------------------------------------------------
  rlf_state_t state_q;
  logic [31:0] gap_q;
  logic pri_en_q;
  logic sec_en_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= RLF_BOTH_OFF;
      gap_q   <= '0;
    end
    else
    begin
      unique case (state_q)
        RLF_PRI_ACT:
          if (pri_fail)
          begin
            state_q <= RLF_GAP;
            gap_q   <= '0;
          end
        RLF_GAP:
          if (gap_q >= 32'(GAP_CYCLES - 1))
            state_q <= sec_fail ? RLF_BOTH_OFF : RLF_SEC_ACT;
          else
            gap_q <= gap_q + 32'd1;
        RLF_SEC_ACT:
          if (sec_fail)
            state_q <= pri_fail ? RLF_BOTH_OFF : RLF_PRI_ACT;
        RLF_BOTH_OFF:
          // at start waits until the primary is clear; after a loss a clear secondary also ends it
          if (!swap_seen_q)
            state_q <= RLF_BOTH_OFF;
          else if (!pri_fail)
            state_q <= RLF_PRI_ACT;
          else if (!sec_fail && gap_q != '0)
            state_q <= RLF_SEC_ACT;
        default:
          state_q <= RLF_BOTH_OFF;
      endcase
    end
  end

  // enables from state, gated by that role's failure: never two at once
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pri_en_q <= 1'b0;
      sec_en_q <= 1'b0;
    end
    else
    begin
      pri_en_q <= (state_q == RLF_PRI_ACT) && !pri_fail;
      sec_en_q <= (state_q == RLF_SEC_ACT) && !sec_fail;
    end
  end

  assign port_a_enable = swap_q ? sec_en_q : pri_en_q;
  assign port_b_enable = swap_q ? pri_en_q : sec_en_q;

  // ----------------------------------------------------------------
  // status and transition count
  // ----------------------------------------------------------------
  logic a_fail_q;
  logic b_fail_q;
  logic sec_q;
  logic [CNT_W-1:0] cnt_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      a_fail_q <= 1'b0;
      b_fail_q <= 1'b0;
      sec_q    <= 1'b0;
    end
    else
    begin
      a_fail_q <= pa.failed;
      b_fail_q <= pb.failed;
      sec_q    <= sec_en_q;
    end
  end

  logic pri_en_d1_q;
  logic sec_en_d1_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q       <= CNT_RST;
      pri_en_d1_q <= 1'b0;
      sec_en_d1_q <= 1'b0;
    end
    else
    begin
      pri_en_d1_q <= pri_en_q;
      sec_en_d1_q <= sec_en_q;
      // saturate so management never sees a wrap
      if (((pri_en_q != pri_en_d1_q) || (sec_en_q != sec_en_d1_q))
          && cnt_q != '1)
        cnt_q <= cnt_q + 1'b1;
    end
  end

  assign port_a_fail      = a_fail_q;
  assign port_b_fail      = b_fail_q;
  assign on_secondary     = sec_q;
  assign transition_count = cnt_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_never_both: assert property (@(posedge clk) disable iff (rst)
    !(pri_en_q && sec_en_q)) else $error("both ports enabled");
  a_pri_first: assert property (@(posedge clk) disable iff (rst)
    $rose(sec_en_q) |-> !pri_en_q && !$past(pri_en_q))
    else $error("secondary on before primary off");
  // the full bound is far past a delay range, so count gap cycles instead
  logic [31:0] gap_run_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      gap_run_q <= '0;
    else if (state_q == RLF_GAP)
      gap_run_q <= gap_run_q + 32'd1;
    else
      gap_run_q <= '0;
  end
  a_switch_bound: assert property (@(posedge clk) disable iff (rst)
    gap_run_q < 32'(SWITCH_MAX_CYC - 2))
    else $error("switchover too slow");
  a_pri_drop: assert property (@(posedge clk) disable iff (rst)
    pri_fail |=> !pri_en_q) else $error("failed primary still on");
  a_stay_sec: assert property (@(posedge clk) disable iff (rst)
    (state_q == RLF_SEC_ACT && !sec_fail) |=> state_q == RLF_SEC_ACT)
    else $error("primary reclaimed early");
  a_start_pri: assert property (@(posedge clk) disable iff (rst)
    (state_q == RLF_BOTH_OFF && swap_seen_q && !pri_fail)
    |=> state_q == RLF_PRI_ACT ##1 (pri_en_q || $past(pri_fail)))
    else $error("primary not enabled at start");
  a_both_fail: assert property (@(posedge clk) disable iff (rst)
    (state_q == RLF_SEC_ACT && sec_fail && pri_fail)
    |=> state_q == RLF_BOTH_OFF) else $error("enable while both fail");
  a_count_up: assert property (@(posedge clk) disable iff (rst)
    ($changed(pri_en_q) && cnt_q != '1) |=> cnt_q == $past(cnt_q) + 1'b1)
    else $error("transition not counted");
  a_status: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> a_fail_q == $past(pa.failed)) else $error("status stale");
  c_failover: cover property (@(posedge clk) disable iff (rst)
    state_q == RLF_GAP ##1 state_q == RLF_SEC_ACT);
  c_back: cover property (@(posedge clk) disable iff (rst)
    state_q == RLF_SEC_ACT ##1 state_q == RLF_PRI_ACT);
  c_dead: cover property (@(posedge clk) disable iff (rst)
    state_q == RLF_SEC_ACT ##1 state_q == RLF_BOTH_OFF);
endmodule : rlf_ctrl

// *** bench/rlf_far_end.sv ***
// model of the remote repeater port facing one master port
`timescale 1ns/1ps
module rlf_far_end
  import rlf_pkg::*;
(
  input  wire logic [rlf_pkg::FW-1:0] local_fault,
  input  wire logic                   rx_broken,
  input  wire logic                   is_responder,
  output logic      [rlf_pkg::FW-1:0] cause,
  output logic                        responder
);
  // only a responder's remote bit means anything; a nonresponder's line
  // is left to wander, so the controller has to mask it on its own
  always_comb
  begin
    cause           = local_fault;
    cause[F_REMOTE] = rx_broken;
    responder       = is_responder;
  end
endmodule : rlf_far_end

// *** bench/rlf_ctrl_bench.sv ***
// self-checking bench for the failover controller
`timescale 1ns/1ps
module rlf_ctrl_bench;
  import rlf_pkg::*;
  localparam int GAP = 8;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic             swap = 1'b0;
  logic [FW-1:0]    loc [2];
  logic             brk [2];
  logic             rsp [2];
  logic [FW-1:0]    ca, cb;
  logic             ra, rb, ea, eb, fa, fb, osec;
  logic [CNT_W-1:0] cnt;
  int               fail_count = 0;
  int               compares = 0;
  int               seed = 32'h17d2;
  wire logic pe = swap ? eb : ea;
  wire logic se = swap ? ea : eb;
  wire logic pf = swap ? fb : fa;
  wire logic sf = swap ? fa : fb;

  always #50 clk = ~clk;

  rlf_far_end u_far_a (.local_fault(loc[0]), .rx_broken(brk[0]),
    .is_responder(rsp[0]), .cause(ca), .responder(ra));
  rlf_far_end u_far_b (.local_fault(loc[1]), .rx_broken(brk[1]),
    .is_responder(rsp[1]), .cause(cb), .responder(rb));
  rlf_ctrl #(.GAP_CYCLES(GAP)) i_rlf_ctrl (.clk(clk), .rst(rst),
    .swap_roles(swap), .port_a_cause(ca), .port_b_cause(cb),
    .port_a_responder(ra), .port_b_responder(rb),
    .port_a_enable(ea), .port_b_enable(eb), .port_a_fail(fa),
    .port_b_fail(fb), .on_secondary(osec), .transition_count(cnt));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic chk(input logic e, input logic g);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected at %0t: exp %h got %h", $time, e, g);
    end
  endtask : chk

  task automatic chk_cnt(input logic [CNT_W-1:0] e,
                         input logic [CNT_W-1:0] g);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected at %0t: exp %h got %h", $time, e, g);
    end
  endtask : chk_cnt

  task automatic final_report;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // one failover episode; faults injected on the primary role, then a reset (mid) or one link loss on the secondary
  // ----------------------------------------------------------------
  task automatic run(input int b, input logic resp, input logic mid);
    int p;
    logic [CNT_W-1:0] c0;
    rst = 1'b1;
    swap = 1'($random(seed));
    p = swap ? 1 : 0;
    for (int i = 0; i < 2; i++)
    begin
      loc[i] = '0;
      brk[i] = 1'b0;
      rsp[i] = resp;
    end
    cyc(10);
    rst = 1'b0;
    cyc(5);
    chk(1'b1, pe);
    chk(1'b0, se);
    c0 = cnt;
    if (b == F_REMOTE) brk[p] = 1'b1;
    else loc[p][b] = 1'b1;
    cyc(3);
    if (b == F_REMOTE && !resp)
    begin
      chk(1'b1, pe);
      return;
    end
    chk(1'b0, pe);
    chk(1'b0, se);
    chk(1'b1, pf);
    cyc(GAP);
    chk(1'b1, se);
    chk(1'b1, osec);
    chk_cnt(c0 + 16'h0002, cnt);
    loc[p] = '0;
    brk[p] = 1'b0;
    if (mid)
    begin
      rst = 1'b1;
      cyc(2);
      rst = 1'b0;
      cyc(5);
      chk(1'b1, pe);
      chk(1'b0, se);
      return;
    end
    cyc(5);
    chk(1'b0, pe);
    chk(1'b0, pf);
    loc[1-p][0] = 1'b1;
    cyc(4);
    chk(1'b0, se);
    chk(1'b1, pe);
    chk(1'b1, sf);
    loc[p][1] = 1'b1;
    cyc(4);
    chk(1'b0, pe);
    chk(1'b0, se);
    cyc(GAP);
    chk(1'b0, pe);
    chk(1'b0, se);
    loc[p][1] = 1'b0;
    cyc(4);
    chk(1'b1, pe);
    chk(1'b0, se);
  endtask : run

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    for (int i = 0; i < 2; i++)
    begin
      loc[i] = '0;
      brk[i] = 1'b0;
      rsp[i] = 1'b0;
    end
    for (int b = 0; b < FW; b++)
      run(b, 1'b1, 1'b0);
    run(F_REMOTE, 1'b0, 1'b0);
    run(F_LINK, 1'b0, 1'b1);
    for (int k = 0; k < 6; k++)
      run(int'($unsigned($random(seed)) % FW), 1'($random(seed)), 1'b0);
    final_report();
  end

  // generous bound: fifteen episodes of under a hundred cycles
  initial
  begin
    #(100 * 20000);
    fail_count++;
    final_report();
  end
endmodule : rlf_ctrl_bench
